// >>> src/iao_map.svh
// Address map and constants for the information area overlay.
// Assumes a 16-bit program memory address and byte-wide data.
`ifndef IAO_MAP_SVH
`define IAO_MAP_SVH
`define IAO_ADDR_W 16
`define IAO_DATA_W 8
`define IAO_PAGE_EN_BIT 7
`define IAO_AREA_BASE 16'hFE00
`define IAO_AREA_LAST 16'hFFFF
`define IAO_AREA_BYTES 512
`define IAO_IDX_W 9
`define IAO_PART_FIRST 9'h040
`define IAO_PART_LAST 9'h053
`define IAO_PART_LEN 20
`define IAO_BLANK_BYTE 8'hFF
`define IAO_NULL_BYTE 8'h00
`define IAO_RESERVED_BYTE 8'hFF
`define IAO_FLASH_TOP_DEF 17'h1_0000
`endif

// >>> src/iao_pkg.sv
// Types for the information area overlay.
// Assumes iao_map.svh is on the include path.
`include "iao_map.svh"
package iao_pkg;
  // Read source class
  typedef enum logic [1:0] {
    IAO_SRC_FETCH,
    IAO_SRC_CONST,
    IAO_SRC_DEBUG
  } iao_src_t;
  // Read request carrier
  typedef struct packed {
    logic valid;
    iao_src_t src;
    logic [`IAO_ADDR_W-1:0] addr;
  } iao_req_t;
  // Read answer carrier
  typedef struct packed {
    logic valid;
    logic [`IAO_DATA_W-1:0] data;
  } iao_rsp_t;
endpackage : iao_pkg

// >>> src/iao_info_rom.sv
// Read-only information area contents, one byte per index.
// Assumes the index is already taken relative to the area base.
`include "iao_map.svh"
module iao_info_rom #(
  parameter logic [8*`IAO_PART_LEN-1:0] PART_ID = {"DEMO-PART-0001", 48'h0}  // Arbitrary id
) (
  input wire logic [`IAO_IDX_W-1:0] i_idx,  // Byte index in area
  output logic [`IAO_DATA_W-1:0] o_data     // Byte at index
);
  // Part id window, reserved bytes elsewhere; no write port exists
  always_comb begin
    o_data = `IAO_RESERVED_BYTE;
    if (i_idx >= `IAO_PART_FIRST && i_idx <= `IAO_PART_LAST) begin
      o_data = PART_ID[8*`IAO_PART_LEN-1-8*(i_idx-`IAO_PART_FIRST) -: 8];
    end
  end
endmodule : iao_info_rom

// >>> src/iao_overlay.sv
// Read steering between program flash and the information area.
// Assumes a flash that answers in the same cycle as its read strobe.
`include "iao_map.svh"
module iao_overlay #(
  parameter logic [`IAO_ADDR_W:0] FLASH_TOP = `IAO_FLASH_TOP_DEF  // Implemented flash bytes
) (
  input wire logic i_clk,                      // System clock
  input wire logic i_rst,                      // Sync reset, high
  input wire logic [`IAO_DATA_W-1:0] i_page_sel,  // Page select register
  input wire iao_pkg::iao_req_t i_req,         // Core/debugger read
  input wire logic i_wr,                       // Program memory write
  input wire logic [`IAO_ADDR_W-1:0] i_wr_addr, // Write address
  input wire logic [`IAO_DATA_W-1:0] i_flash_data, // Flash read data
  output iao_pkg::iao_rsp_t o_rsp,             // Read answer
  output logic o_flash_rd,                     // Flash read strobe
  output logic [`IAO_ADDR_W-1:0] o_flash_addr, // Flash address
  output logic o_flash_wr                      // Flash write strobe
);
  // ==========================================================
  // Decode
  function automatic logic in_area(input logic [`IAO_ADDR_W-1:0] a);
    in_area = (a >= `IAO_AREA_BASE);
  endfunction : in_area

  function automatic logic in_flash(input logic [`IAO_ADDR_W-1:0] a);
    in_flash = ({1'b0, a} < FLASH_TOP);
  endfunction : in_flash

  logic area_en;
  logic use_info;
  logic [`IAO_DATA_W-1:0] info_byte;
  assign area_en = i_page_sel[`IAO_PAGE_EN_BIT];
  // Fetches never overlaid; only program space requests handled
  assign use_info = i_req.valid && area_en && in_area(i_req.addr)
                    && (i_req.src != iao_pkg::IAO_SRC_FETCH);

  iao_info_rom u_rom (
    .i_idx(i_req.addr[`IAO_IDX_W-1:0]),
    .o_data(info_byte)
  );

  // ==========================================================
  // Answer pipeline: two cycle latency for every source
  logic pend_flash_reg;
  logic pend_info_reg;
  logic pend_blank_reg;
  logic [`IAO_DATA_W-1:0] info_reg;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pend_flash_reg <= 1'b0;
      pend_info_reg <= 1'b0;
      pend_blank_reg <= 1'b0;
      info_reg <= `IAO_NULL_BYTE;
    end else begin
      pend_info_reg <= use_info;
      pend_flash_reg <= i_req.valid && !use_info && in_flash(i_req.addr);
      pend_blank_reg <= i_req.valid && !use_info && !in_flash(i_req.addr);
      info_reg <= info_byte;
    end
  end

  // Flash strobes from flops
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_flash_rd <= 1'b0;
      o_flash_addr <= '0;
      o_flash_wr <= 1'b0;
    end else begin
      o_flash_rd <= i_req.valid && !use_info && in_flash(i_req.addr);
      o_flash_addr <= i_wr ? i_wr_addr : i_req.addr;
      // Writes to info area (when on) or beyond flash dropped
      o_flash_wr <= i_wr && in_flash(i_wr_addr)
                    && !(area_en && in_area(i_wr_addr));
    end
  end

  // Answer mux registered: data two cycles after request
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rsp <= '0;
    end else begin
      o_rsp.valid <= pend_flash_reg || pend_info_reg || pend_blank_reg;
      o_rsp.data <= pend_info_reg ? info_reg :
                    pend_blank_reg ? `IAO_BLANK_BYTE : i_flash_data;
    end
  end

  // ==========================================================
  // Checks
  fetch_flash_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_req.valid && i_req.src == iao_pkg::IAO_SRC_FETCH && in_flash(i_req.addr)
    |=> o_flash_rd) else $error("fetch not sent to flash");
  info_data_a: assert property (@(posedge i_clk) disable iff (i_rst)
    use_info |=> !o_flash_rd ##1 (o_rsp.valid && o_rsp.data == $past(info_reg)))
    else $error("info read wrong");
  gate_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !area_en |-> !use_info) else $error("overlay while disabled");
  blank_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_req.valid && !in_flash(i_req.addr) && !use_info
    |=> ##1 o_rsp.valid && o_rsp.data == `IAO_BLANK_BYTE)
    else $error("unimplemented read not FFh");
  wr_block_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr && area_en && in_area(i_wr_addr) |=> !o_flash_wr)
    else $error("info area written");
  debug_info_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_req.valid && area_en && in_area(i_req.addr) && i_req.src == iao_pkg::IAO_SRC_DEBUG
    |-> use_info) else $error("debug read not overlaid");
  area_low_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_req.valid && i_req.addr < `IAO_AREA_BASE |-> !use_info)
    else $error("overlay below base");
  clear_normal_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_req.valid && !area_en && in_flash(i_req.addr) |=> o_flash_rd)
    else $error("disabled read not flash");
  rsp_count_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_req.valid |=> ##1 o_rsp.valid) else $error("answer missing");

  // ==========================================================
  // Further checks, some multi-step ones built from named sequences

  // Read that must go out to the flash array
  sequence flash_req_s;
    i_req.valid && !i_wr && !use_info && in_flash(i_req.addr);
  endsequence

  // Flash strobe carrying the address of the read before
  sequence flash_strobe_s;
    o_flash_rd && (o_flash_addr == $past(i_req.addr));
  endsequence

  // Answer carrying what the flash returned a cycle before
  sequence rsp_flash_s;
    o_rsp.valid && (o_rsp.data == $past(i_flash_data));
  endsequence

  // Fetch into the overlaid range with the overlay switched on
  sequence fetch_area_s;
    i_req.valid && !i_wr && area_en && in_area(i_req.addr)
    && in_flash(i_req.addr) && (i_req.src == iao_pkg::IAO_SRC_FETCH);
  endsequence

  // Overlaid read of a byte outside the part id window
  sequence info_reserved_s;
    use_info && ((i_req.addr[`IAO_IDX_W-1:0] < `IAO_PART_FIRST)
    || (i_req.addr[`IAO_IDX_W-1:0] > `IAO_PART_LAST));
  endsequence

  // Write that must reach the flash untouched
  sequence wr_pass_s;
    i_wr && !area_en && in_flash(i_wr_addr);
  endsequence

  // Flash path: strobe, then answer with flash data
  flash_path_a: assert property (@(posedge i_clk) disable iff (i_rst)
    flash_req_s |=> flash_strobe_s ##1 rsp_flash_s)
    else $error("flash read path broken");

  // Fetches keep program memory even when the overlay is on
  fetch_area_a: assert property (@(posedge i_clk) disable iff (i_rst)
    fetch_area_s |=> flash_strobe_s ##1 rsp_flash_s)
    else $error("fetch served from info area");

  // Reserved info bytes answer the reserved value
  info_rsvd_a: assert property (@(posedge i_clk) disable iff (i_rst)
    info_reserved_s |=> ##1 (o_rsp.valid && o_rsp.data == `IAO_RESERVED_BYTE))
    else $error("reserved info byte wrong");

  // Writes within flash made with the overlay switched off reach the flash
  wr_pass_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_pass_s |=> (o_flash_wr && o_flash_addr == $past(i_wr_addr)))
    else $error("normal write lost");

  // Writes beyond the implemented flash never reach it
  wr_beyond_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr && !in_flash(i_wr_addr) |=> !o_flash_wr)
    else $error("write beyond flash passed");

  // No flash strobe without a read the cycle before
  rd_cause_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_flash_rd |-> $past(i_req.valid))
    else $error("spurious flash read");

  // No write strobe without a write the cycle before
  wr_cause_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_flash_wr |-> $past(i_wr))
    else $error("spurious flash write");

  // No answer without a request two cycles before
  rsp_cause_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_req.valid |=> ##1 !o_rsp.valid)
    else $error("spurious answer");

  // Overlaid reads leave the flash alone
  info_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
    use_info && !i_wr |=> !o_flash_rd)
    else $error("flash read on overlay");
endmodule : iao_overlay

// >>> bench/iao_flash_model.sv
// Flash array model for the overlay; each byte is derived from its address.
// Assumes read strobe and address arrive registered off the rising edge.
module iao_flash_model (
  input wire logic i_clk,          // System clock
  input wire logic i_rd,           // Flash read strobe
  input wire logic [15:0] i_addr,  // Flash read address
  output logic [7:0] o_data        // Flash read data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] last_reg = 8'h00;
  // Remember the last byte so idle data never repeats it
  always @(posedge i_clk) begin
    last_reg <= o_data;
  end
  // Data valid only while the strobe stands, otherwise inverted
  assign o_data = i_rd ? (i_addr[7:0] ^ i_addr[15:8] ^ 8'h5A) : ~last_reg;
endmodule : iao_flash_model

// >>> bench/iao_overlay_bench.sv
// Bench for the overlay: random reads and writes checked against a model.
// Assumes the src files are compiled first and iao_map.svh is on the path.
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin error_cnt++; $display("mismatch %s exp %h got %h", n, e, s); end end
module iao_overlay_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [16:0] TOP = 17'h0_FF00;
  localparam logic [159:0] PID = {"DEMO-PART-0001", 48'h0};
  logic i_clk, i_rst, i_wr, o_flash_rd, o_flash_wr, w1, en, r1;
  logic [7:0] i_page_sel, i_flash_data;
  logic [15:0] i_wr_addr, o_flash_addr, a, a1;
  iao_pkg::iao_req_t i_req;
  iao_pkg::iao_rsp_t o_rsp, e1, e2;
  int error_cnt = 0;
  int total_checks = 0;
  // ==========================================
  // Design, flash partner and clock
  iao_overlay #(.FLASH_TOP(TOP)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_page_sel(i_page_sel),
    .i_req(i_req), .i_wr(i_wr), .i_wr_addr(i_wr_addr), .i_flash_data(i_flash_data),
    .o_rsp(o_rsp), .o_flash_rd(o_flash_rd), .o_flash_addr(o_flash_addr), .o_flash_wr(o_flash_wr));
  iao_flash_model flash (.i_clk(i_clk), .i_rd(o_flash_rd), .i_addr(o_flash_addr),
    .o_data(i_flash_data));
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // ==========================================
  // Expected read byte for a source, enable and address
  function automatic logic [7:0] exp_byte(iao_pkg::iao_src_t s, logic on, logic [15:0] ad);
    if (s != iao_pkg::IAO_SRC_FETCH && on && ad >= 16'hFE00) begin
      if (ad >= 16'hFE40 && ad <= 16'hFE53) return PID[8*(19-int'(ad-16'hFE40)) +: 8];
      return 8'hFF;
    end
    if ({1'b0, ad} >= TOP) return 8'hFF;
    return ad[7:0] ^ ad[15:8] ^ 8'h5A;
  endfunction : exp_byte
  // Print counts and verdict, then stop
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  // ==========================================
  // Main sequence: reset, then pipelined random traffic
  initial begin
    i_rst = 1'b1;
    i_req = '0;
    i_wr = 1'b0;
    i_wr_addr = '0;
    i_page_sel = '0;
    e1 = '0;
    e2 = '0;
    w1 = 1'b0;
    r1 = 1'b0;
    a1 = '0;
    void'($urandom(87641));
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    `CHK("rsp_valid_rst", 1'b0, o_rsp.valid)
    i_rst = 1'b0;
    for (int k = 0; k < 3000; k++) begin
      @(negedge i_clk);
      `CHK("rsp_valid", e2.valid, o_rsp.valid)
      if (e2.valid) `CHK("rsp_data", e2.data, o_rsp.data)
      `CHK("flash_wr", w1, o_flash_wr)
      `CHK("flash_rd", r1, o_flash_rd)
      if (r1 || w1) `CHK("flash_addr", a1, o_flash_addr)
      e2 = e1;
      a = ($urandom_range(2) == 0) ? 16'($urandom) : {7'h7F, 9'($urandom)};
      en = 1'($urandom);
      i_page_sel = {en, 7'($urandom)};
      i_wr = ($urandom_range(3) == 0);
      i_wr_addr = a;
      i_req.valid = !i_wr && ($urandom_range(3) != 0);
      i_req.src = iao_pkg::iao_src_t'($urandom_range(2));
      i_req.addr = a;
      e1.valid = i_req.valid;
      e1.data = exp_byte(i_req.src, en, a);
      w1 = i_wr && !(en && a >= 16'hFE00) && ({1'b0, a} < TOP);
      r1 = i_req.valid && ({1'b0, a} < TOP)
           && !(i_req.src != iao_pkg::IAO_SRC_FETCH && en && a >= 16'hFE00);
      a1 = a;
    end
    test_done();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #40000;
    error_cnt++;
    test_done();
  end
endmodule : iao_overlay_bench
